// file: shared/ssf_pkg.sv
// package: register map, field positions, reset values and carrier types of the sensor status block
package ssf_pkg;
  localparam logic [7:0] ADDR_SENSOR_FLAGS    = 8'h03;
  localparam logic [7:0] ADDR_PRESS_LOW       = 8'h04;
  localparam logic [7:0] ADDR_PRESS_MID       = 8'h05;
  localparam logic [7:0] ADDR_PRESS_HIGH      = 8'h06;
  localparam logic [7:0] ADDR_TEMP_LOW        = 8'h07;
  localparam logic [7:0] ADDR_TEMP_MID        = 8'h08;
  localparam logic [7:0] ADDR_TEMP_HIGH       = 8'h09;
  localparam logic [7:0] ADDR_TIME_LOW        = 8'h0c;
  localparam logic [7:0] ADDR_TIME_MID        = 8'h0d;
  localparam logic [7:0] ADDR_TIME_HIGH       = 8'h0e;
  localparam logic [7:0] ADDR_EVENT_FLAGS     = 8'h10;
  localparam logic [7:0] ADDR_IRQ_FLAGS       = 8'h11;
  localparam logic [7:0] ADDR_LEVEL_LOW       = 8'h12;
  localparam logic [7:0] ADDR_LEVEL_HIGH      = 8'h13;
  localparam logic [7:0] ADDR_READ_PORT       = 8'h14;
  localparam logic [7:0] ADDR_THRESH_LOW      = 8'h15;
  localparam logic [7:0] ADDR_THRESH_HIGH     = 8'h16;
  localparam logic [7:0] ADDR_CONTENT_SETUP   = 8'h17;
  localparam logic [7:0] ADDR_SOURCE_SETUP    = 8'h18;
  localparam logic [7:0] ADDR_IRQ_SETUP       = 8'h19;
  // sensor_flags bits
  localparam int BIT_CMD_READY   = 4;
  localparam int BIT_PRESS_READY = 5;
  localparam int BIT_TEMP_READY  = 6;
  // sticky_event_flags bits
  localparam int BIT_POWER_UP    = 0;
  localparam int BIT_BUS_CONV    = 1;
  // irq_flags bits
  localparam int BIT_IRQ_WTM     = 0;
  localparam int BIT_IRQ_FULL    = 1;
  localparam int BIT_IRQ_DRDY    = 3;
  // queue_content_setup bits
  localparam int BIT_Q_ENABLE    = 0;
  localparam int BIT_Q_STOP_FULL = 1;
  localparam int BIT_Q_TIME_EN   = 2;
  localparam int BIT_Q_PRESS_EN  = 3;
  localparam int BIT_Q_TEMP_EN   = 4;
  // queue_source_setup fields
  localparam int SUBS_LSB        = 0;
  localparam int SRC_LSB         = 3;
  localparam logic [1:0] SRC_FILTERED = 2'h1;
  // irq setup bits
  localparam int BIT_IRQ_OD      = 0;
  localparam int BIT_IRQ_LEVEL   = 1;
  localparam int BIT_IRQ_LATCH   = 2;
  localparam int BIT_IRQ_WTM_EN  = 3;
  localparam int BIT_IRQ_FULL_EN = 4;
  localparam int BIT_IRQ_DRDY_EN = 6;
  // reset values
  localparam logic [7:0]  RST_THRESH_LOW  = 8'h01;
  localparam logic [7:0]  RST_THRESH_HIGH = 8'h00;
  localparam logic [7:0]  RST_CONTENT     = 8'h02;
  localparam logic [7:0]  RST_SOURCE      = 8'h02;
  localparam logic [7:0]  RST_IRQ_SETUP   = 8'h02;
  localparam logic [23:0] RST_RESULT      = 24'h80_0000;
  // queue geometry and frame headers
  localparam int          QUEUE_DEPTH     = 512;
  localparam logic [9:0]  QUEUE_DEPTH_L   = 10'h200;
  localparam logic [9:0]  BUF_SLACK       = 10'h002;
  localparam logic [7:0]  HDR_DATA        = 8'h80;
  localparam logic [7:0]  HDR_TIME        = 8'ha0;
  localparam logic [7:0]  HDR_EMPTY       = 8'h80;
  typedef struct packed {
    logic [23:0] press;
    logic [23:0] temp;
  } ssf_sample_type;
  typedef struct packed {
    logic [7:0] data;
  } ssf_byte_type;
  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_EMIT = 2'b01
  } ssf_ser_state_type;
endpackage

// file: rtl/ssf_regs.sv
// sensor status, result and queue register bank with its byte queue
`timescale 1ns/1ps
module ssf_regs
  import ssf_pkg::*;
(
  input  wire logic           mclk,
  input  wire logic           rst_b,
  input  wire logic [7:0]     reg_addr,
  input  wire logic           reg_rd,
  input  wire logic           reg_wr,
  input  wire logic [7:0]     reg_wdata,
  output logic      [7:0]     reg_rdata,
  output logic                reg_rvalid,
  input  wire logic           sample_valid,
  input  wire ssf_sample_type sample_raw,
  input  wire ssf_sample_type sample_filt,
  input  wire logic [23:0]    sensor_time,
  input  wire logic           cmd_busy,
  input  wire logic           conv_busy,
  input  wire logic           soft_reset,
  output logic                int_o,
  output logic                int_oe
);
  function automatic logic [7:0] pick_byte(input logic [23:0] word, input logic [1:0] idx);
    pick_byte = (idx == 2'd0) ? word[7:0] : (idx == 2'd1) ? word[15:8] : word[23:16];
  endfunction

  logic [7:0]        mem [0:QUEUE_DEPTH-1];
  logic [7:0]        thresh_low_reg, thresh_high_reg, content_reg, source_reg, irq_setup_reg;
  logic [23:0]       press_reg, temp_reg;
  logic              press_rdy_reg, temp_rdy_reg, power_up_reg, bus_conv_reg;
  logic              irq_wtm_reg, irq_full_reg, irq_drdy_reg;
  logic [8:0]        rd_ptr_reg, wr_ptr_reg;
  logic [9:0]        count_reg;
  logic [6:0]        subs_cnt_reg;
  logic [1:0]        time_idx_reg;
  ssf_ser_state_type ser_state_reg;
  logic [55:0]       frame_reg;
  logic [2:0]        frame_len_reg, frame_idx_reg;
  ssf_byte_type      buf_reg [0:1];
  logic              buf_head_reg, buf_tail_reg;
  logic [1:0]        buf_cnt_reg;
  logic [7:0]        rdata_next;

  // register access decode
  wire        rd_press    = reg_rd && (reg_addr >= ADDR_PRESS_LOW) && (reg_addr <= ADDR_PRESS_HIGH);
  wire        rd_temp     = reg_rd && (reg_addr >= ADDR_TEMP_LOW) && (reg_addr <= ADDR_TEMP_HIGH);
  wire        rd_event    = reg_rd && (reg_addr == ADDR_EVENT_FLAGS);
  wire        rd_irq      = reg_rd && (reg_addr == ADDR_IRQ_FLAGS);
  wire        rd_port     = reg_rd && (reg_addr == ADDR_READ_PORT);
  wire        q_empty     = (count_reg == 10'h000);
  wire        pop         = rd_port && !q_empty;
  wire        time_frame  = rd_port && q_empty && content_reg[BIT_Q_TIME_EN];
  wire [8:0]  watermark   = {thresh_high_reg[0], thresh_low_reg};
  wire        use_filt    = (source_reg[SRC_LSB +: 2] == SRC_FILTERED);
  wire        ssf_sample_type src = use_filt ? sample_filt : sample_raw;
  wire        press_en    = content_reg[BIT_Q_PRESS_EN];
  wire        temp_en     = content_reg[BIT_Q_TEMP_EN];
  wire [2:0]  new_len     = 3'd1 + (temp_en ? 3'd3 : 3'd0) + (press_en ? 3'd3 : 3'd0);
  wire [6:0]  subs_top    = 7'((8'h01 << source_reg[SUBS_LSB +: 3]) - 8'h01);
  wire        subs_hit    = (subs_cnt_reg == 7'h00);
  wire        frame_fits  = (count_reg + 10'(new_len) + BUF_SLACK) <= QUEUE_DEPTH_L;
  wire        frame_start = sample_valid && subs_hit && content_reg[BIT_Q_ENABLE] && (press_en || temp_en) &&
                            (ser_state_reg == SER_IDLE) && (frame_fits || !content_reg[BIT_Q_STOP_FULL]);
  // buffer handshakes
  wire        buf_in_valid  = (ser_state_reg == SER_EMIT);
  wire        buf_in_ready  = (buf_cnt_reg != 2'd2);
  wire        buf_push      = buf_in_valid && buf_in_ready;
  wire        buf_out_valid = (buf_cnt_reg != 2'd0);
  wire        buf_out_ready = !pop;
  wire        buf_pop       = buf_out_valid && buf_out_ready;
  wire        q_full        = (count_reg == QUEUE_DEPTH_L);
  wire        q_write       = buf_pop && !(q_full && content_reg[BIT_Q_STOP_FULL]);
  wire        q_overwrite   = q_write && q_full;
  wire [7:0]  frame_byte    = frame_reg[{frame_idx_reg, 3'b000} +: 8];
  wire        cond_wtm      = ({1'b0, watermark} <= count_reg) && (watermark != 9'h000);
  wire        cond_full     = (count_reg + 10'(new_len)) > QUEUE_DEPTH_L;
  wire        set_wtm       = cond_wtm && irq_setup_reg[BIT_IRQ_WTM_EN];
  wire        set_full      = cond_full && irq_setup_reg[BIT_IRQ_FULL_EN];
  wire        set_drdy      = sample_valid && irq_setup_reg[BIT_IRQ_DRDY_EN];
  wire        latch_on      = irq_setup_reg[BIT_IRQ_LATCH];
  wire        irq_any       = irq_wtm_reg || irq_full_reg || irq_drdy_reg;
  wire [7:0]  time_byte     = (time_idx_reg == 2'd0) ? HDR_TIME : pick_byte(sensor_time, 2'(time_idx_reg - 2'd1));

  // read data mux
  always_comb begin
    rdata_next = 8'h00;
    unique case (reg_addr)
      ADDR_SENSOR_FLAGS: begin
        rdata_next[BIT_CMD_READY]   = !cmd_busy;
        rdata_next[BIT_PRESS_READY] = press_rdy_reg;
        rdata_next[BIT_TEMP_READY]  = temp_rdy_reg;
      end
      ADDR_PRESS_LOW:     rdata_next = pick_byte(press_reg, 2'd0);
      ADDR_PRESS_MID:     rdata_next = pick_byte(press_reg, 2'd1);
      ADDR_PRESS_HIGH:    rdata_next = pick_byte(press_reg, 2'd2);
      ADDR_TEMP_LOW:      rdata_next = pick_byte(temp_reg, 2'd0);
      ADDR_TEMP_MID:      rdata_next = pick_byte(temp_reg, 2'd1);
      ADDR_TEMP_HIGH:     rdata_next = pick_byte(temp_reg, 2'd2);
      ADDR_TIME_LOW:      rdata_next = pick_byte(sensor_time, 2'd0);
      ADDR_TIME_MID:      rdata_next = pick_byte(sensor_time, 2'd1);
      ADDR_TIME_HIGH:     rdata_next = pick_byte(sensor_time, 2'd2);
      ADDR_EVENT_FLAGS:   rdata_next = {6'h00, bus_conv_reg, power_up_reg};
      ADDR_IRQ_FLAGS:     rdata_next = {4'h0, irq_drdy_reg, 1'b0, irq_full_reg, irq_wtm_reg};
      ADDR_LEVEL_LOW:     rdata_next = count_reg[7:0];
      ADDR_LEVEL_HIGH:    rdata_next = {6'h00, count_reg[9:8]};
      ADDR_READ_PORT:     rdata_next = !q_empty ? mem[rd_ptr_reg] : (content_reg[BIT_Q_TIME_EN] ? time_byte : HDR_EMPTY);
      ADDR_THRESH_LOW:    rdata_next = thresh_low_reg;
      ADDR_THRESH_HIGH:   rdata_next = thresh_high_reg;
      ADDR_CONTENT_SETUP: rdata_next = content_reg;
      ADDR_SOURCE_SETUP:  rdata_next = source_reg;
      ADDR_IRQ_SETUP:     rdata_next = irq_setup_reg;
      default:            rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata  <= reg_rd ? rdata_next : reg_rdata;
      reg_rvalid <= reg_rd;
    end
  end

  // host-writable setup registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      thresh_low_reg  <= RST_THRESH_LOW;
      thresh_high_reg <= RST_THRESH_HIGH;
      content_reg     <= RST_CONTENT;
      source_reg      <= RST_SOURCE;
      irq_setup_reg   <= RST_IRQ_SETUP;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_THRESH_LOW)    thresh_low_reg  <= reg_wdata;
      if (reg_addr == ADDR_THRESH_HIGH)   thresh_high_reg <= {7'h00, reg_wdata[0]};
      if (reg_addr == ADDR_CONTENT_SETUP) content_reg     <= {3'h0, reg_wdata[4:0]};
      if (reg_addr == ADDR_SOURCE_SETUP)  source_reg      <= {3'h0, reg_wdata[4:0]};
      if (reg_addr == ADDR_IRQ_SETUP)     irq_setup_reg   <= {1'b0, reg_wdata[6:0]};
    end
  end

  // results and status flags; a set in the clearing cycle wins
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      press_reg     <= RST_RESULT;
      temp_reg      <= RST_RESULT;
      press_rdy_reg <= 1'b0;
      temp_rdy_reg  <= 1'b0;
      power_up_reg  <= 1'b1;
      bus_conv_reg  <= 1'b0;
    end else begin
      if (sample_valid) begin
        press_reg <= src.press;
        temp_reg  <= src.temp;
      end
      press_rdy_reg <= sample_valid || (press_rdy_reg && !rd_press);
      temp_rdy_reg  <= sample_valid || (temp_rdy_reg && !rd_temp);
      power_up_reg  <= soft_reset || (power_up_reg && !rd_event);
      bus_conv_reg  <= ((reg_rd || reg_wr) && conv_busy) || (bus_conv_reg && !rd_event);
    end
  end

  // interrupt flags, latched or following their conditions
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq_wtm_reg  <= 1'b0;
      irq_full_reg <= 1'b0;
      irq_drdy_reg <= 1'b0;
    end else if (latch_on) begin
      irq_wtm_reg  <= set_wtm || (irq_wtm_reg && !rd_irq);
      irq_full_reg <= set_full || (irq_full_reg && !rd_irq);
      irq_drdy_reg <= set_drdy || (irq_drdy_reg && !rd_irq);
    end else begin
      irq_wtm_reg  <= set_wtm;
      irq_full_reg <= set_full;
      irq_drdy_reg <= set_drdy;
    end
  end

  assign int_o  = irq_setup_reg[BIT_IRQ_LEVEL] ? irq_any : !irq_any;
  assign int_oe = !irq_setup_reg[BIT_IRQ_OD] || !int_o;

  // subsampling and frame serialiser
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      subs_cnt_reg  <= 7'h00;
      ser_state_reg <= SER_IDLE;
      frame_reg     <= 56'h00_0000_0000_0000;
      frame_len_reg <= 3'd0;
      frame_idx_reg <= 3'd0;
    end else begin
      if (sample_valid) begin
        subs_cnt_reg <= subs_hit ? subs_top : 7'(subs_cnt_reg - 7'h01);
      end
      unique case (ser_state_reg)
        SER_IDLE: begin
          if (frame_start) begin
            ser_state_reg <= SER_EMIT;
            frame_len_reg <= new_len;
            frame_idx_reg <= 3'd0;
            frame_reg     <= temp_en ? {src.press, src.temp, HDR_DATA | {3'b000, temp_en, press_en, 3'b000}}
                                     : {24'h00_0000, src.press, HDR_DATA | {3'b000, temp_en, press_en, 3'b000}};
          end
        end
        SER_EMIT: begin
          if (buf_push) begin
            frame_idx_reg <= 3'(frame_idx_reg + 3'd1);
            if (3'(frame_idx_reg + 3'd1) == frame_len_reg) begin
              ser_state_reg <= SER_IDLE;
            end
          end
        end
      endcase
    end
  end

  // two-entry buffer between serialiser and queue
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      buf_reg[0]   <= '0;
      buf_reg[1]   <= '0;
      buf_head_reg <= 1'b0;
      buf_tail_reg <= 1'b0;
      buf_cnt_reg  <= 2'd0;
    end else begin
      if (buf_push) begin
        buf_reg[buf_tail_reg].data <= frame_byte;
        buf_tail_reg               <= !buf_tail_reg;
      end
      if (buf_pop) begin
        buf_head_reg <= !buf_head_reg;
      end
      buf_cnt_reg <= 2'(buf_cnt_reg + {1'b0, buf_push} - {1'b0, buf_pop});
    end
  end

  // queue storage
  always_ff @(posedge mclk) begin
    if (q_write) begin
      mem[wr_ptr_reg] <= buf_reg[buf_head_reg].data;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_ptr_reg   <= 9'h000;
      wr_ptr_reg   <= 9'h000;
      count_reg    <= 10'h000;
      time_idx_reg <= 2'd0;
    end else begin
      if (q_write) begin
        wr_ptr_reg <= 9'(wr_ptr_reg + 9'h001);
      end
      if (pop || q_overwrite) begin
        rd_ptr_reg <= 9'(rd_ptr_reg + 9'h001);
      end
      if (pop) begin
        count_reg <= 10'(count_reg - 10'h001);
      end else if (q_write && !q_full) begin
        count_reg <= 10'(count_reg + 10'h001);
      end
      if (!q_empty) begin
        time_idx_reg <= 2'd0;
      end else if (time_frame) begin
        time_idx_reg <= 2'(time_idx_reg + 2'd1);
      end
    end
  end

  // checks
  property p_cmd_ready;
    @(posedge mclk) disable iff (!rst_b) reg_rd && reg_addr == ADDR_SENSOR_FLAGS |=> reg_rdata[BIT_CMD_READY] == !$past(cmd_busy);
  endproperty
  a_cmd_ready: assert property (p_cmd_ready) else $error("command ready bit wrong");
  property p_press_clear;
    @(posedge mclk) disable iff (!rst_b) rd_press && !sample_valid |=> !press_rdy_reg;
  endproperty
  a_press_clear: assert property (p_press_clear) else $error("pressure ready not cleared");
  property p_temp_set;
    @(posedge mclk) disable iff (!rst_b) sample_valid |=> temp_rdy_reg && press_rdy_reg;
  endproperty
  a_temp_set: assert property (p_temp_set) else $error("data ready not set");
  property p_event_clear;
    @(posedge mclk) disable iff (!rst_b) rd_event && !soft_reset |=> !power_up_reg;
  endproperty
  a_event_clear: assert property (p_event_clear) else $error("event flag not cleared");
  property p_bus_conv;
    @(posedge mclk) disable iff (!rst_b) reg_wr && conv_busy |=> bus_conv_reg;
  endproperty
  a_bus_conv: assert property (p_bus_conv) else $error("bus during conversion not flagged");
  property p_pop_level;
    @(posedge mclk) disable iff (!rst_b) pop |=> count_reg == $past(count_reg) - 10'h001;
  endproperty
  a_pop_level: assert property (p_pop_level) else $error("level not lowered by read");
  property p_disabled;
    @(posedge mclk) disable iff (!rst_b) sample_valid && !content_reg[BIT_Q_ENABLE] && ser_state_reg == SER_IDLE
      |=> ser_state_reg == SER_IDLE;
  endproperty
  a_disabled: assert property (p_disabled) else $error("frame started with queue off");
  property p_stop_full;
    @(posedge mclk) disable iff (!rst_b) content_reg[BIT_Q_STOP_FULL] && q_full |=> $stable(wr_ptr_reg);
  endproperty
  a_stop_full: assert property (p_stop_full) else $error("write into full queue");
  property p_wtm_enable;
    @(posedge mclk) disable iff (!rst_b) !irq_setup_reg[BIT_IRQ_WTM_EN] && !latch_on |=> !irq_wtm_reg;
  endproperty
  a_wtm_enable: assert property (p_wtm_enable) else $error("watermark irq while disabled");
  property p_level_bound;
    @(posedge mclk) disable iff (!rst_b) count_reg <= QUEUE_DEPTH_L;
  endproperty
  a_level_bound: assert property (p_level_bound) else $error("level beyond depth");
  property p_rvalid;
    @(posedge mclk) disable iff (!rst_b) reg_rd |=> reg_rvalid;
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer missing");
  property p_drdy_enable;
    @(posedge mclk) disable iff (!rst_b) !irq_setup_reg[BIT_IRQ_DRDY_EN] && !latch_on |=> !irq_drdy_reg;
  endproperty
  a_drdy_enable: assert property (p_drdy_enable) else $error("data ready irq while disabled");
  property p_irq_clear;
    @(posedge mclk) disable iff (!rst_b) rd_irq && !set_wtm && !set_full && !set_drdy |=> !irq_any;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq flags not cleared by read");
  property p_overwrite;
    @(posedge mclk) disable iff (!rst_b) q_overwrite |=> count_reg == QUEUE_DEPTH_L;
  endproperty
  a_overwrite: assert property (p_overwrite) else $error("overwrite changed the level");
  property p_time_step;
    @(posedge mclk) disable iff (!rst_b) time_frame |=> time_idx_reg == 2'($past(time_idx_reg) + 2'd1);
  endproperty
  a_time_step: assert property (p_time_step) else $error("time frame did not advance");
  property p_wtm_reach;
    @(posedge mclk) disable iff (!rst_b) irq_setup_reg[BIT_IRQ_WTM_EN] && watermark != 9'h000 &&
      count_reg >= {1'b0, watermark} |=> irq_wtm_reg;
  endproperty
  a_wtm_reach: assert property (p_wtm_reach) else $error("watermark reached without irq");
  property p_soft_reset;
    @(posedge mclk) disable iff (!rst_b) soft_reset |=> power_up_reg;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset event not flagged");
  c_frame: cover property (@(posedge mclk) disable iff (!rst_b) frame_start ##[1:20] pop);
  c_stall: cover property (@(posedge mclk) disable iff (!rst_b) buf_out_valid && !buf_out_ready);
  c_full:  cover property (@(posedge mclk) disable iff (!rst_b) q_overwrite);
  c_time:  cover property (@(posedge mclk) disable iff (!rst_b) time_frame);
endmodule

// file: sim/ssf_front_model.sv
// front-end model: delivers one conversion result a few cycles after a trigger
`timescale 1ns/1ps
module ssf_front_model
  import ssf_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        fire,
  input  wire logic [47:0] value,
  output logic             sample_valid,
  output ssf_sample_type   sample_raw,
  output ssf_sample_type   sample_filt,
  output logic             conv_busy
);
  logic [2:0] cnt_reg;
  assign conv_busy = (cnt_reg != 3'h0);
  // raw results are inverted outside the valid pulse, filtered results are inverted during it
  assign sample_raw  = sample_valid ? value : ~value;
  assign sample_filt = sample_valid ? ~value : value;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg      <= 3'h0;
      sample_valid <= 1'b0;
    end else begin
      sample_valid <= (cnt_reg == 3'h1);
      if (fire) begin
        cnt_reg <= 3'h4;
      end else if (conv_busy) begin
        cnt_reg <= cnt_reg - 3'h1;
      end
    end
  end
endmodule

// file: sim/tb_ssf_regs.sv
// self-checking bench of the status, result and queue register bank
`timescale 1ns/1ps
module tb_ssf_regs import ssf_pkg::*; ;
  logic           mclk, rst_b, reg_rd, reg_wr, reg_rvalid, sample_valid, cmd_busy, conv_busy;
  logic           soft_reset, int_o, int_oe, fire;
  logic [7:0]     reg_addr, reg_wdata, reg_rdata, d;
  logic [23:0]    sensor_time;
  logic [47:0]    value;
  ssf_sample_type sample_raw, sample_filt;
  int             num_errors, checks, i;
  localparam logic [15:0] ROWS [0:21] = '{16'h0310, 16'h0400, 16'h0500, 16'h0680, 16'h0700, 16'h0800,
    16'h0980, 16'h0cef, 16'h0dcd, 16'h0eab, 16'h1001, 16'h1000, 16'h1100, 16'h1200, 16'h1300,
    16'h1501, 16'h1600, 16'h1702, 16'h1802, 16'h1902, 16'h0b00, 16'h2000};
  localparam logic [7:0] FRAME [0:6] = '{8'h98, 8'h21, 8'h43, 8'h65, 8'h56, 8'h34, 8'h12};
  ssf_regs u_ssf_regs (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sample_valid(sample_valid),
    .sample_raw(sample_raw), .sample_filt(sample_filt), .sensor_time(sensor_time), .cmd_busy(cmd_busy),
    .conv_busy(conv_busy), .soft_reset(soft_reset), .int_o(int_o), .int_oe(int_oe));
  ssf_front_model u_ssf_front_model (.mclk(mclk), .rst_b(rst_b), .fire(fire), .value(value),
    .sample_valid(sample_valid), .sample_raw(sample_raw), .sample_filt(sample_filt), .conv_busy(conv_busy));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    d = reg_rdata;
    chk({7'h00, reg_rvalid}, 8'h01);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    chk(d, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask
  task automatic send();
    @(negedge mclk);
    fire = 1'b1;
    @(negedge mclk);
    fire = 1'b0;
    repeat (20) @(negedge mclk);
  endtask
  task automatic conclude();
    $display("counts: %0d checks, %0d mismatches", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    conclude();
  end
  initial begin
    rst_b = 1'b0;
    {reg_rd, reg_wr, cmd_busy, soft_reset, fire} = 5'h00;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    sensor_time = 24'hab_cdef;
    value = 48'h1234_5665_4321;
    repeat (16) @(posedge mclk);
    @(negedge mclk) rst_b = 1'b1;
    for (i = 0; i < 22; i++) rc(ROWS[i][15:8], ROWS[i][7:0]);
    $display("test reset_table done");
    wr(ADDR_THRESH_LOW, 8'h05);
    wr(ADDR_THRESH_HIGH, 8'h01);
    rc(ADDR_THRESH_LOW, 8'h05);
    rc(ADDR_THRESH_HIGH, 8'h01);
    cmd_busy = 1'b1;
    rc(ADDR_SENSOR_FLAGS, 8'h00);
    cmd_busy = 1'b0;
    $display("test threshold_and_busy done");
    wr(ADDR_THRESH_LOW, 8'h07);
    wr(ADDR_THRESH_HIGH, 8'h00);
    wr(ADDR_CONTENT_SETUP, 8'h19);
    wr(ADDR_SOURCE_SETUP, 8'h00);
    wr(ADDR_IRQ_SETUP, 8'h4e);
    send();
    rc(ADDR_SENSOR_FLAGS, 8'h70);
    rc(ADDR_PRESS_MID, 8'h34);
    rc(ADDR_SENSOR_FLAGS, 8'h50);
    rc(ADDR_TEMP_HIGH, 8'h65);
    rc(ADDR_SENSOR_FLAGS, 8'h10);
    rc(ADDR_LEVEL_LOW, 8'h07);
    chk({6'h00, int_o, int_oe}, 8'h03);
    rc(ADDR_IRQ_FLAGS, 8'h09);
    for (i = 0; i < 7; i++) rc(ADDR_READ_PORT, FRAME[i]);
    rc(ADDR_LEVEL_LOW, 8'h00);
    rd(ADDR_IRQ_FLAGS);
    rc(ADDR_IRQ_FLAGS, 8'h00);
    $display("test frame done");
    wr(ADDR_CONTENT_SETUP, 8'h18);
    for (i = 0; i < 4; i++) begin
      wr(ADDR_SOURCE_SETUP, 8'(i << 3));
      send();
      rc(ADDR_PRESS_LOW, (i == 1) ? 8'ha9 : 8'h56);
    end
    rc(ADDR_LEVEL_LOW, 8'h00);
    $display("test source done");
    @(negedge mclk) fire = 1'b1;
    @(negedge mclk) fire = 1'b0;
    rd(ADDR_SENSOR_FLAGS);
    repeat (10) @(negedge mclk);
    rc(ADDR_EVENT_FLAGS, 8'h02);
    rc(ADDR_EVENT_FLAGS, 8'h00);
    @(negedge mclk) soft_reset = 1'b1;
    @(negedge mclk) soft_reset = 1'b0;
    rc(ADDR_EVENT_FLAGS, 8'h01);
    $display("test events done");
    wr(ADDR_CONTENT_SETUP, 8'h05);
    rc(ADDR_READ_PORT, 8'ha0);
    rc(ADDR_READ_PORT, 8'hef);
    wr(ADDR_CONTENT_SETUP, 8'h19);
    wr(ADDR_SOURCE_SETUP, 8'h01);
    send();
    send();
    rc(ADDR_LEVEL_LOW, 8'h07);
    $display("test time_and_subsample done");
    wr(ADDR_SOURCE_SETUP, 8'h00);
    wr(ADDR_IRQ_SETUP, 8'h14);
    for (i = 0; i < 73; i++) send();
    rc(ADDR_LEVEL_HIGH, 8'h02);
    rc(ADDR_LEVEL_LOW, 8'h00);
    rd(ADDR_IRQ_FLAGS);
    rc(ADDR_IRQ_FLAGS, 8'h02);
    wr(ADDR_CONTENT_SETUP, 8'h1b);
    send();
    rc(ADDR_LEVEL_HIGH, 8'h02);
    rc(ADDR_READ_PORT, 8'h12);
    send();
    rc(ADDR_LEVEL_LOW, 8'hff);
    wr(ADDR_IRQ_SETUP, 8'h01);
    @(negedge mclk);
    chk({6'h00, int_o, int_oe}, 8'h02);
    $display("test fill done");
    @(negedge mclk) rst_b = 1'b0;
    repeat (2) @(negedge mclk);
    rst_b = 1'b1;
    rc(ADDR_LEVEL_HIGH, 8'h00);
    rc(ADDR_EVENT_FLAGS, 8'h01);
    rc(ADDR_CONTENT_SETUP, 8'h02);
    chk({6'h00, int_o, int_oe}, 8'h01);
    $display("test reset_midrun done");
    conclude();
  end
endmodule
